// file: core/ckg_clock_ctrl.sv
// Purpose: trim register, protected system clock divider, sleep gating
// Assumes: all inputs synchronous to sys_clk; fuses stable at reset
// Notes: divided rates leave as one-cycle enables, never as clocks
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module ckg_clock_ctrl
  import ckg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire ckg_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] fuse_trim_value,
  input wire logic divide_by_eight_fuse,
  input wire logic sleep_exec,
  input wire ckg_wake_t wake_src,
  input wire logic async_timer_async,
  input wire logic brownout_sleep_req,
  output logic [7:0] osc_trim,
  output logic sys_tick,
  output ckg_dom_t dom_run,
  output logic cpu_run,
  output logic wake_irq_go,
  output logic brownout_detector_off
);

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode

  logic wr_trim;
  logic wr_div;
  logic wr_slp;
  logic loaded_ff;
  logic [7:0] trim_ff;
  logic ce_ff;
  logic [1:0] ce_cnt_ff;
  logic [3:0] ratio_ff;
  logic [3:0] act_ratio_ff;
  logic pend_ff;
  logic [7:0] div_cnt_ff;
  logic [7:0] div_mask;
  logic div_hit;
  logic slp_en_ff;
  logic [2:0] slp_mode_ff;
  ckg_slp_state_t state_ff;
  ckg_slp_state_t nxt_state;
  logic [7:0] wait_cnt_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic mode_legal;
  logic wake_ok;
  logic wake_irq_ff;
  logic ce_write;
  logic ratio_write;

  assign wr_trim = reg_req.wr && (reg_req.addr == OFF_OSC_TRIM);
  assign wr_div = reg_req.wr && (reg_req.addr == OFF_DIV_CTRL);
  assign wr_slp = reg_req.wr && (reg_req.addr == OFF_SLEEP_CTRL);

  // Only 0x80 exactly arms the window
  assign ce_write = wr_div && (reg_req.wdata == 8'h80);
  // A ratio write is one with bit 7 low, accepted only inside the window
  assign ratio_write = wr_div && ce_ff && !reg_req.wdata[DIV_CE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Fuses load on the first edge after release: reset takes constants only

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      loaded_ff <= 1'b0;
    end else begin
      loaded_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator trim: range and tuning are analog, only the code leaves

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trim_ff <= 8'h00;
    end else if (!loaded_ff) begin
      trim_ff <= fuse_trim_value;
    end else if (wr_trim) begin
      trim_ff <= reg_req.wdata;
    end
  end

  assign osc_trim = trim_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Change-enable window

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ce_ff <= 1'b0;
      ce_cnt_ff <= 2'h0;
    end else if (ce_ff) begin
      // Re-arming inside the window is ignored on purpose
      if (ratio_write || (ce_cnt_ff == 2'h0)) begin
        ce_ff <= 1'b0;
      end else begin
        ce_cnt_ff <= ce_cnt_ff - 2'h1;
      end
    end else if (ce_write) begin
      ce_ff <= 1'b1;
      ce_cnt_ff <= DIV_CE_WINDOW;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ratio register

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ratio_ff <= DIV_RATIO_RST;
    end else if (!loaded_ff) begin
      ratio_ff <= divide_by_eight_fuse ? DIV_RATIO_FUSE : DIV_RATIO_RST;
    end else if (ratio_write && (reg_req.wdata[3:0] <= DIV_RATIO_MAX)) begin
      ratio_ff <= reg_req.wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A new ratio waits for the old period to end, so no period is short

  assign div_mask = 8'((9'h001 << act_ratio_ff) - 9'h001);
  assign div_hit = ((div_cnt_ff & div_mask) == div_mask);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      act_ratio_ff <= DIV_RATIO_RST;
      pend_ff <= 1'b0;
      div_cnt_ff <= 8'h00;
    end else if (!loaded_ff) begin
      act_ratio_ff <= divide_by_eight_fuse ? DIV_RATIO_FUSE : DIV_RATIO_RST;
      div_cnt_ff <= 8'h00;
    end else begin
      if (ratio_write && (reg_req.wdata[3:0] <= DIV_RATIO_MAX)) begin
        pend_ff <= 1'b1;
      end else if (pend_ff && div_hit) begin
        pend_ff <= 1'b0;
      end
      if (pend_ff && div_hit) begin
        act_ratio_ff <= ratio_ff;
        div_cnt_ff <= 8'h00;
      end else begin
        div_cnt_ff <= div_cnt_ff + 8'h01;
      end
    end
  end

  // Held off until fuses are in so the first tick uses the right ratio
  assign sys_tick = loaded_ff && div_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Sleep control register

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      slp_en_ff <= 1'b0;
      slp_mode_ff <= SM_IDLE;
    end else if (wr_slp) begin
      slp_en_ff <= reg_req.wdata[SLP_EN_BIT];
      slp_mode_ff <= reg_req.wdata[SLP_MODE_LSB +: 3];
    end
  end

  always_comb begin
    unique case (slp_mode_ff)
      SM_IDLE, SM_NOISE, SM_PDOWN, SM_PSAVE, SM_STBY, SM_XSTBY: begin
        mode_legal = 1'b1;
      end
      default: begin
        mode_legal = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake qualification per mode

  always_comb begin
    wake_ok = wake_src.ext_level || wake_src.pin_change_irq ||
              wake_src.two_wire_match || wake_src.watchdog_unit;
    unique case (slp_mode_ff)
      SM_IDLE: begin
        wake_ok = wake_ok || wake_src.ext_edge || wake_src.async_timer ||
                  wake_src.mem_ready || wake_src.conv_done ||
                  wake_src.other_io;
      end
      SM_NOISE: begin
        // Edge-mode external pins do not count outside idle
        wake_ok = wake_ok || wake_src.mem_ready || wake_src.conv_done ||
                  (wake_src.async_timer && async_timer_async);
      end
      SM_PSAVE, SM_XSTBY: begin
        wake_ok = wake_ok || wake_src.async_timer;
      end
      default: begin
        wake_ok = wake_ok;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep sequencer; register file and SRAM sit outside, untouched
  // rstn returns it to run and the CPU restarts from its vector

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SLP_RUN: begin
        if (sleep_exec && slp_en_ff && mode_legal) begin
          nxt_state = SLP_SLEEP;
        end
      end
      SLP_SLEEP: begin
        if (wake_ok) begin
          nxt_state = SLP_START;
        end
      end
      SLP_START: begin
        if (wait_cnt_ff == 8'h01) begin
          nxt_state = SLP_HOLD;
        end
      end
      SLP_HOLD: begin
        if (wait_cnt_ff == 8'h01) begin
          nxt_state = SLP_RUN;
        end
      end
      default: begin
        nxt_state = SLP_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= SLP_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wait_cnt_ff <= 8'h00;
    end else if (state_ff == SLP_SLEEP) begin
      wait_cnt_ff <= STARTUP_CYC;
    end else if ((state_ff == SLP_START) && (wait_cnt_ff == 8'h01)) begin
      wait_cnt_ff <= {5'h00, WAKE_HOLD_CYC};
    end else if (wait_cnt_ff != 8'h00) begin
      wait_cnt_ff <= wait_cnt_ff - 8'h01;
    end
  end

  // Handler start pulse once the hold ends
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wake_irq_ff <= 1'b0;
    end else begin
      wake_irq_ff <= (state_ff == SLP_HOLD) && (wait_cnt_ff == 8'h01);
    end
  end

  assign wake_irq_go = wake_irq_ff;
  assign cpu_run = (state_ff == SLP_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Domain gating; clocks restart during start-up, CPU waits for hold end

  always_comb begin
    dom_run = '{default: 1'b1};
    if (state_ff == SLP_SLEEP) begin
      dom_run.cpu = 1'b0;
      dom_run.flash = 1'b0;
      unique case (slp_mode_ff)
        SM_IDLE: begin
          dom_run.timer_osc = async_timer_async;
        end
        SM_NOISE: begin
          dom_run.io = 1'b0;
          dom_run.asy = async_timer_async;
          dom_run.timer_osc = async_timer_async;
        end
        SM_PSAVE, SM_XSTBY: begin
          dom_run.io = 1'b0;
          dom_run.conv = 1'b0;
          dom_run.asy = async_timer_async;
          dom_run.timer_osc = async_timer_async;
          dom_run.main_osc = (slp_mode_ff == SM_XSTBY);
        end
        default: begin
          dom_run.io = 1'b0;
          dom_run.conv = 1'b0;
          dom_run.asy = 1'b0;
          dom_run.timer_osc = 1'b0;
          dom_run.main_osc = (slp_mode_ff == SM_STBY);
        end
      endcase
    end else if (state_ff != SLP_RUN) begin
      dom_run.cpu = 1'b0;
    end
  end

  assign brownout_detector_off = (state_ff == SLP_SLEEP) &&
                                 brownout_sleep_req &&
                                 (slp_mode_ff != SM_IDLE) &&
                                 (slp_mode_ff != SM_NOISE);

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data valid only in the cycle after the strobe

  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        OFF_OSC_TRIM: nxt_rdata = trim_ff;
        OFF_DIV_CTRL: nxt_rdata = {ce_ff, 3'h0, ratio_ff};
        OFF_SLEEP_CTRL: nxt_rdata = {4'h0, slp_mode_ff, slp_en_ff};
        OFF_SLEEP_STAT: nxt_rdata = {4'h0, pend_ff, act_ratio_ff == 4'h0,
                                     state_ff == SLP_HOLD,
                                     state_ff == SLP_SLEEP};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule

// file: core/ckg_pkg.sv
// Purpose: shared constants and carriers for the clock control block
// Assumes: 8-bit register port, 125 MHz master clock
// Notes: sleep control and status offsets sit in a free corner of the map
package ckg_pkg;

  localparam int unsigned SYS_CLK_MHZ = 125;

  // Register offsets
  localparam logic [7:0] OFF_SLEEP_CTRL = 8'h53;
  localparam logic [7:0] OFF_SLEEP_STAT = 8'h54;
  localparam logic [7:0] OFF_DIV_CTRL = 8'h61;
  localparam logic [7:0] OFF_OSC_TRIM = 8'h66;

  // Divider control fields
  localparam int unsigned DIV_CE_BIT = 7;
  localparam logic [3:0] DIV_RATIO_MAX = 4'h8;
  localparam logic [3:0] DIV_RATIO_RST = 4'h0;
  localparam logic [3:0] DIV_RATIO_FUSE = 4'h3;
  localparam logic [1:0] DIV_CE_WINDOW = 2'h3;

  // Sleep control fields
  localparam int unsigned SLP_EN_BIT = 0;
  localparam int unsigned SLP_MODE_LSB = 1;
  localparam logic [2:0] SM_IDLE = 3'h0;
  localparam logic [2:0] SM_NOISE = 3'h1;
  localparam logic [2:0] SM_PDOWN = 3'h2;
  localparam logic [2:0] SM_PSAVE = 3'h3;
  localparam logic [2:0] SM_STBY = 3'h6;
  localparam logic [2:0] SM_XSTBY = 3'h7;

  // Wake timing in master cycles
  localparam logic [7:0] STARTUP_CYC = 8'h06;
  localparam logic [2:0] WAKE_HOLD_CYC = 3'h4;

  typedef enum logic [3:0] {
    SLP_RUN = 4'b0001,
    SLP_SLEEP = 4'b0010,
    SLP_START = 4'b0100,
    SLP_HOLD = 4'b1000
  } ckg_slp_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ckg_reg_req_t;

  typedef struct packed {
    logic ext_level;
    logic ext_edge;
    logic pin_change_irq;
    logic two_wire_match;
    logic watchdog_unit;
    logic async_timer;
    logic mem_ready;
    logic conv_done;
    logic other_io;
  } ckg_wake_t;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic conv;
    logic asy;
    logic main_osc;
    logic timer_osc;
  } ckg_dom_t;

endpackage

// file: sim/ckg_clock_ctrl_monitor.sv
// Purpose: port assertions for the clock control block
// Assumes: sleep ctrl resets to zero
// Notes: sleep ctrl has no port, so it is shadowed from bus writes
`timescale 1ns/1ns
module ckg_clock_ctrl_monitor
  import ckg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire ckg_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic sleep_exec,
  input wire ckg_wake_t wake_src,
  input wire logic [7:0] osc_trim,
  input wire ckg_dom_t dom_run,
  input wire logic cpu_run,
  input wire logic wake_irq_go,
  input wire logic brownout_detector_off
);
  logic [3:0] slp_ff;
  logic [2:0] md;
  logic [3:0] halt_cnt_ff;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  assign md = slp_ff[3:1];
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      slp_ff <= 4'h0;
    else if (reg_req.wr && reg_req.addr == OFF_SLEEP_CTRL)
      slp_ff <= reg_req.wdata[3:0];
  end
  // Counts stalled CPU cycles; saturates so a long sleep cannot wrap
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      halt_cnt_ff <= 4'h0;
    else if (cpu_run)
      halt_cnt_ff <= 4'h0;
    else if (halt_cnt_ff != 4'hF)
      halt_cnt_ff <= halt_cnt_ff + 4'h1;
  end
  ////////////////////////////////////////
  sequence s_halt;
    !cpu_run;
  endsequence
  sequence s_resume;
    cpu_run && wake_irq_go && halt_cnt_ff == 4'hB;
  endsequence
  property p_wake;
    sleep_exec && cpu_run && slp_ff[0] && md == SM_IDLE
      && wake_src.other_io |=> s_halt ##11 s_resume;
  endproperty
  a_wake: assert property (p_wake) else $error("idle wake timing");
  property p_trim_wr;
    reg_req.wr && reg_req.addr == OFF_OSC_TRIM
      |=> osc_trim == $past(reg_req.wdata);
  endproperty
  a_trim_wr: assert property (p_trim_wr) else $error("trim lost");
  property p_trim_rd;
    reg_req.rd && reg_req.addr == OFF_OSC_TRIM
      |=> reg_rdata == $past(osc_trim);
  endproperty
  a_trim_rd: assert property (p_trim_rd) else $error("trim read");
  property p_div_rd;
    reg_req.rd && reg_req.addr == OFF_DIV_CTRL
      |=> reg_rdata[6:4] == 3'h0 && reg_rdata[3:0] <= DIV_RATIO_MAX;
  endproperty
  a_div_rd: assert property (p_div_rd) else $error("div read");
  property p_refuse;
    sleep_exec && cpu_run && !slp_ff[0] |=> cpu_run;
  endproperty
  a_refuse: assert property (p_refuse) else $error("slept");
  property p_enter;
    $fell(cpu_run) |-> $past(sleep_exec) && $past(slp_ff[0]);
  endproperty
  a_enter: assert property (p_enter) else $error("odd sleep");
  property p_idle_dom;
    $fell(cpu_run) && md == SM_IDLE
      |-> !dom_run.cpu && !dom_run.flash && dom_run.io;
  endproperty
  a_idle_dom: assert property (p_idle_dom) else $error("idle dom");
  property p_pdown_dom;
    $fell(cpu_run) && md == SM_PDOWN |-> dom_run == 7'h00;
  endproperty
  a_pdown_dom: assert property (p_pdown_dom) else $error("pdown");
  property p_bod;
    brownout_detector_off |-> !cpu_run && md[2:1] != 2'h0;
  endproperty
  a_bod: assert property (p_bod) else $error("brownout off");
  property p_run_dom;
    cpu_run |-> dom_run.cpu && dom_run.flash;
  endproperty
  a_run_dom: assert property (p_run_dom) else $error("run dom");
endmodule
bind ckg_clock_ctrl ckg_clock_ctrl_monitor i_mon (
  .sys_clk(sys_clk), .rstn(rstn), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .sleep_exec(sleep_exec), .wake_src(wake_src),
  .osc_trim(osc_trim), .dom_run(dom_run), .cpu_run(cpu_run),
  .wake_irq_go(wake_irq_go), .brownout_detector_off(brownout_detector_off)
);

// file: sim/ckg_clock_ctrl_test.sv
// Purpose: directed test of trim, divider and sleep gating
// Assumes: async timer mode and brownout request held high
// Notes: writes take two cycles so the unlock window is hit exactly
`timescale 1ns/1ns
module ckg_clock_ctrl_test
  import ckg_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  ckg_reg_req_t reg_req = '0;
  logic [7:0] fuse_trim_value = 8'hA5;
  logic divide_by_eight_fuse = 1'b1;
  logic sleep_exec = 1'b0;
  ckg_wake_t wake_src = '0;
  logic async_timer_async = 1'b1;
  logic brownout_sleep_req = 1'b1;
  logic [7:0] reg_rdata, osc_trim;
  logic sys_tick, cpu_run, wake_irq_go, brownout_detector_off;
  ckg_dom_t dom_run;
  int n_mismatch = 0;
  int compares = 0;
  logic [7:0] tv[4] = '{8'h7F, 8'h80, 8'h00, 8'hFF};
  logic [2:0] md[6] = '{SM_IDLE, SM_NOISE, SM_PDOWN, SM_PSAVE, SM_STBY,
    SM_XSTBY};
  logic [6:0] dr[6] = '{7'h1F, 7'h0F, 7'h00, 7'h05, 7'h02, 7'h07};
  ckg_clock_ctrl i_dut (.sys_clk(sys_clk), .rstn(rstn),
    .reg_req(reg_req), .reg_rdata(reg_rdata),
    .fuse_trim_value(fuse_trim_value),
    .divide_by_eight_fuse(divide_by_eight_fuse),
    .sleep_exec(sleep_exec), .wake_src(wake_src),
    .async_timer_async(async_timer_async),
    .brownout_sleep_req(brownout_sleep_req), .osc_trim(osc_trim),
    .sys_tick(sys_tick), .dom_run(dom_run), .cpu_run(cpu_run),
    .wake_irq_go(wake_irq_go),
    .brownout_detector_off(brownout_detector_off));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      n_mismatch++;
      $display("[FAIL] %0t wait ran out", $time);
      end_sim();
    end
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(osc_trim, fuse_trim_value);
    chk(cpu_run, 1'b1);
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    reg_req <= '0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    reg_req <= '0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
    @(posedge sys_clk);
  endtask
  // First pass may land on the switch tick, so the last one is measured
  task automatic gap(input logic [15:0] e);
    int n;
    n = 0;
    repeat (3) begin
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (sys_tick !== 1'b1 && n < 600);
      bound(n, 600);
    end
    chk(16'(n), e);
    @(posedge sys_clk);
  endtask
  task automatic go();
    sleep_exec <= 1'b1;
    @(posedge sys_clk);
    sleep_exec <= 1'b0;
    @(negedge sys_clk);
  endtask
  ////////////////////////////////////////
  initial begin
    int n;
    ckg_wake_t w;
    do_reset();
    rd(OFF_DIV_CTRL, 8'h03);
    rd(8'h10, 8'h00);
    foreach (tv[i]) begin
      wr(OFF_OSC_TRIM, tv[i]);
      chk(osc_trim, tv[i]);
      rd(OFF_OSC_TRIM, tv[i]);
    end
    wr(OFF_DIV_CTRL, 8'h05);
    rd(OFF_DIV_CTRL, 8'h03);
    wr(OFF_DIV_CTRL, 8'h81);
    wr(OFF_DIV_CTRL, 8'h05);
    rd(OFF_DIV_CTRL, 8'h03);
    wr(OFF_DIV_CTRL, 8'h80);
    rd(OFF_DIV_CTRL, 8'h83);
    wr(OFF_DIV_CTRL, 8'h00);
    rd(OFF_DIV_CTRL, 8'h00);
    wr(OFF_DIV_CTRL, 8'h80);
    wr(OFF_DIV_CTRL, 8'h80);
    @(posedge sys_clk);
    wr(OFF_DIV_CTRL, 8'h02);
    rd(OFF_DIV_CTRL, 8'h00);
    wr(OFF_DIV_CTRL, 8'h80);
    wr(OFF_DIV_CTRL, 8'h80);
    wr(OFF_DIV_CTRL, 8'h04);
    rd(OFF_DIV_CTRL, 8'h04);
    for (int c = 0; c <= 8; c++) begin
      wr(OFF_DIV_CTRL, 8'h80);
      wr(OFF_DIV_CTRL, 8'(c));
      gap(16'h0001 << c);
    end
    wr(OFF_DIV_CTRL, 8'h80);
    wr(OFF_DIV_CTRL, 8'h09);
    rd(OFF_DIV_CTRL, 8'h08);
    wr(OFF_SLEEP_CTRL, 8'h00);
    go();
    chk(cpu_run, 1'b1);
    @(posedge sys_clk);
    wr(OFF_SLEEP_CTRL, 8'h09);
    go();
    chk(cpu_run, 1'b1);
    @(posedge sys_clk);
    for (int i = 0; i < 6; i++) begin
      w = '0;
      w.other_io = 1'b1;
      w.ext_edge = (i != 0);
      wr(OFF_SLEEP_CTRL, {4'h0, md[i], 1'b1});
      rd(OFF_SLEEP_CTRL, {4'h0, md[i], 1'b1});
      wake_src <= w;
      go();
      chk(dom_run, dr[i]);
      chk(brownout_detector_off, i > 1);
      repeat (3) @(negedge sys_clk);
      chk(cpu_run, 1'b0);
      @(posedge sys_clk);
      w.ext_level = 1'b1;
      wake_src <= w;
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (cpu_run !== 1'b1 && n < 40);
      bound(n, 40);
      chk(wake_irq_go, 1'b1);
      @(posedge sys_clk);
      wake_src <= '0;
    end
    wr(OFF_SLEEP_CTRL, 8'h05);
    go();
    chk(cpu_run, 1'b0);
    @(posedge sys_clk);
    rd(OFF_SLEEP_STAT, 8'h01);
    fuse_trim_value <= 8'h3C;
    divide_by_eight_fuse <= 1'b0;
    do_reset();
    rd(OFF_DIV_CTRL, 8'h00);
    end_sim();
  end
endmodule
